/* rtl/channel_ctrl_defs.svh */
`ifndef CHANNEL_CTRL_DEFS_SVH
`define CHANNEL_CTRL_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TRIP_RATIO_SELECT_ADDR      8'h5e
`define INPUT_PIN_STATUS_ADDR       8'h60
`define CHANNEL_ENABLE_CONTROL_ADDR 8'h69

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TRIP_RATIO_RESET      8'hff
`define ENABLE_RESET_STRAP_HI 8'haa
`define ENABLE_RESET_STRAP_LO 8'h00

// ----------------------------------------
// Field positions in input_pin_status
// ----------------------------------------
`define STATUS_REQ_LSB  0
`define STATUS_MODE_LSB 4
`define STATUS_PROT_LSB 6

// ----------------------------------------
// Ratio encodings, percent
// ----------------------------------------
`define RATIO_PCT_00 8'd125
`define RATIO_PCT_01 8'd150
`define RATIO_PCT_10 8'd175
`define RATIO_PCT_11 8'd200

`endif

/* rtl/channel_ctrl_pkg.sv */
package channel_ctrl_pkg;
    typedef enum logic [1:0] {
        GROUP_ALL    = 2'b00,
        GROUP_PAIRED = 2'b01,
        GROUP_INDEP  = 2'b10
    } group_mode_e;

    typedef enum logic [1:0] {
        PROT_ALERT    = 2'b00,
        PROT_PG       = 2'b01,
        PROT_SHUTDOWN = 2'b10
    } prot_mode_e;
endpackage : channel_ctrl_pkg

/* rtl/channel_enable_and_trip_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "channel_ctrl_defs.svh"

// Overview of operation
// - Channel enable is majority of host bit, strap bit and request pin.
// - Switch drive on only above supply lockout and when majority is true.
// - Strap bits load from hardware strap when supply leaves lockout.
// - Host enable bits reset to zero.
// - Pin-status bits 3:0 show each channel's request comparator.
// - Status bits 5:4 report grouping mode; 11 never reported.
// - Status bits 7:6 report critical-fault response, and it is obeyed.
// - Drive stays on below both trips, latches off when either is exceeded until the channel is commanded off.
// - Fast-trip threshold is 8-bit code over a selected sense range.
// - Slow-trip threshold follows fast-trip by one of four ratios.
// - Ratio register: two bits per channel, resets to 0xFF.
// - Ratio codes 00..11 give 125, 150, 175, 200 percent.
// - Paired mode shuts both of a pair; grouped mode shuts all.
module channel_enable_and_trip_config
    import channel_ctrl_pkg::*;
#(
    parameter int NCH = 4
) (
    // Clock and reset
    input  wire logic                       clock,
    input  wire logic                       srst,
    // Register port
    input  wire logic                       reg_wr,
    input  wire logic [7:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    output logic      [7:0]                 reg_rdata,
    // Supply and straps
    input  wire logic                       supply_ok,
    input  wire logic                       hardware_enable_strap,
    input  wire channel_ctrl_pkg::group_mode_e group_mode,
    input  wire channel_ctrl_pkg::prot_mode_e  prot_mode,
    // Per-channel inputs
    input  wire logic [NCH-1:0]             switch_request_state,
    input  wire logic [NCH-1:0]             slow_trip,
    input  wire logic [NCH-1:0]             fast_trip,
    input  wire logic [NCH-1:0]             critical_fault,
    // Outputs
    output logic      [NCH-1:0]             mosfet_drive,
    output logic                            power_good_out,
    output logic      [8*NCH-1:0]           slow_ratio_pct
);
    import channel_ctrl_pkg::*;

    logic [7:0]     trip_ratio_r;
    logic [NCH-1:0] host_channel_enable_r;
    logic [NCH-1:0] strap_channel_enable_r;
    logic [NCH-1:0] fault_off_r;
    logic           supply_ok_r;
    logic [NCH-1:0] majority;
    logic [NCH-1:0] fault_now;
    logic [NCH-1:0] shut_nxt;
    logic [7:0]     pin_status;
    logic [7:0]     enable_reg;
    logic [1:0]     mode_code;
    logic           enable_wr;
    logic           ratio_wr;

    function automatic logic [7:0] ratio_pct(input logic [1:0] code);
        unique case (code)
            2'b00: ratio_pct = `RATIO_PCT_00;
            2'b01: ratio_pct = `RATIO_PCT_01;
            2'b10: ratio_pct = `RATIO_PCT_10;
            2'b11: ratio_pct = `RATIO_PCT_11;
        endcase
    endfunction : ratio_pct

    // Write strobe aimed at one register address
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] target);
        wr_hit = wr && addr == target;
    endfunction : wr_hit

    // ----------------------------------------
    // Per-channel decode
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign majority[g] = (host_channel_enable_r[g] & strap_channel_enable_r[g])
                               | (host_channel_enable_r[g] & switch_request_state[g])
                               | (strap_channel_enable_r[g] & switch_request_state[g]);
            assign fault_now[g] = slow_trip[g] | fast_trip[g]
                                | (critical_fault[g] && prot_mode == PROT_SHUTDOWN);
            assign enable_reg[2*g]   = host_channel_enable_r[g];
            assign enable_reg[2*g+1] = strap_channel_enable_r[g];
        end
    endgenerate

    always_comb begin
        shut_nxt = fault_now;
        unique case (group_mode)
            GROUP_ALL:    shut_nxt = {NCH{|fault_now}};
            GROUP_PAIRED: begin
                for (int i = 0; i < NCH; i++) begin
                    shut_nxt[i] = fault_now[i] | fault_now[(i + 2) % NCH];
                end
            end
            GROUP_INDEP:  shut_nxt = fault_now;
            default:      shut_nxt = fault_now;
        endcase
    end

    // fold code 11
    // Three-state mode pin cannot give 11; shown as independent, as it acts
    assign mode_code = (group_mode == 2'b11) ? GROUP_INDEP : group_mode;

    assign pin_status = {prot_mode, mode_code, switch_request_state[3:0]};

    // ----------------------------------------
    // Register write decode
    // ----------------------------------------
    // Read-only and unmapped addresses decode to no strobe at all
    assign enable_wr = wr_hit(reg_wr, reg_addr, `CHANNEL_ENABLE_CONTROL_ADDR);
    assign ratio_wr  = wr_hit(reg_wr, reg_addr, `TRIP_RATIO_SELECT_ADDR);

    // ----------------------------------------
    // Supply edge and strap load
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            supply_ok_r <= 1'b0;
        end else begin
            supply_ok_r <= supply_ok;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            strap_channel_enable_r <= '0;
        end else if (supply_ok && !supply_ok_r) begin
            strap_channel_enable_r <= {NCH{hardware_enable_strap}};
        end else if (enable_wr) begin
            for (int i = 0; i < NCH; i++) begin
                strap_channel_enable_r[i] <= reg_wdata[2*i+1];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            host_channel_enable_r <= '0;
        end else if (enable_wr) begin
            for (int i = 0; i < NCH; i++) begin
                host_channel_enable_r[i] <= reg_wdata[2*i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            trip_ratio_r <= `TRIP_RATIO_RESET;
        end else if (ratio_wr) begin
            trip_ratio_r <= reg_wdata;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Latched off until channel is re-commanded off
    always_ff @(posedge clock) begin
        if (srst) begin
            fault_off_r <= '0;
        end else begin
            fault_off_r <= (fault_off_r & majority) | shut_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mosfet_drive <= '0;
        end else begin
            mosfet_drive <= (supply_ok ? majority : '0) & ~shut_nxt & ~fault_off_r;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            power_good_out <= 1'b0;
        end else begin
            power_good_out <= supply_ok && !(|critical_fault && prot_mode != PROT_ALERT);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            slow_ratio_pct <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                slow_ratio_pct[8*i +: 8] <= ratio_pct(trip_ratio_r[2*i +: 2]);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                `TRIP_RATIO_SELECT_ADDR:      reg_rdata <= trip_ratio_r;
                `INPUT_PIN_STATUS_ADDR:       reg_rdata <= pin_status;
                `CHANNEL_ENABLE_CONTROL_ADDR: reg_rdata <= enable_reg;
                default:                      reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule : channel_enable_and_trip_config

`default_nettype wire

/* dv/chan_cfg_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module chan_cfg_asserts
    import channel_ctrl_pkg::*;
#(
    parameter int NCH = 4
) (
    // Clock, reset and register port
    input wire logic                          clock,
    input wire logic                          srst,
    input wire logic                          reg_wr,
    input wire logic [7:0]                    reg_addr,
    input wire logic [7:0]                    reg_wdata,
    input wire logic [7:0]                    reg_rdata,
    // Pins and outputs
    input wire logic                          supply_ok,
    input wire channel_ctrl_pkg::group_mode_e group_mode,
    input wire channel_ctrl_pkg::prot_mode_e  prot_mode,
    input wire logic [NCH-1:0]                switch_request_state,
    input wire logic [NCH-1:0]                slow_trip,
    input wire logic [NCH-1:0]                fast_trip,
    input wire logic [NCH-1:0]                critical_fault,
    input wire logic [NCH-1:0]                mosfet_drive,
    input wire logic                          power_good_out,
    input wire logic [8*NCH-1:0]              slow_ratio_pct
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // Sampled reset keeps the release edge out of the antecedents
    status_read_a: assert property (!srst && reg_addr == 8'h60 |=>
        reg_rdata == {$past(prot_mode), $past(group_mode), $past(switch_request_state)})
        else $error("status read wrong");
    trip_drive_off_a: assert property ((slow_trip | fast_trip) != 0 |=>
        (mosfet_drive & $past(slow_trip | fast_trip)) == 0) else $error("drive kept on trip");
    pair_spread_a: assert property (group_mode == GROUP_PAIRED && (slow_trip[0] | fast_trip[0]) |=>
        !mosfet_drive[2]) else $error("pair not shut");
    group_spread_a: assert property (group_mode == GROUP_ALL && (slow_trip | fast_trip) != 0 |=>
        mosfet_drive == 0) else $error("group not shut");
    lockout_off_a: assert property (!supply_ok |=> mosfet_drive == 0) else $error("drive in lockout");
    pg_lockout_a: assert property (!supply_ok |=> !power_good_out) else $error("good in lockout");
    pg_critical_a: assert property (prot_mode != PROT_ALERT && critical_fault != 0 |=>
        !power_good_out) else $error("good kept on fault");
    pg_alert_a: assert property (!srst && supply_ok && prot_mode == PROT_ALERT |=> power_good_out)
        else $error("good dropped");
    ratio_decode_a: assert property (reg_wr && reg_addr == 8'h5e |-> ##2
        slow_ratio_pct[7:0] == 8'd125 + 8'd25 * $past(reg_wdata[1:0], 2)) else $error("ratio wrong");
endmodule : chan_cfg_asserts
bind channel_enable_and_trip_config chan_cfg_asserts #(.NCH(NCH)) chan_cfg_asserts_i (.clock(clock),
    .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .supply_ok(supply_ok), .group_mode(group_mode), .prot_mode(prot_mode),
    .switch_request_state(switch_request_state), .slow_trip(slow_trip), .fast_trip(fast_trip),
    .critical_fault(critical_fault), .mosfet_drive(mosfet_drive), .power_good_out(power_good_out),
    .slow_ratio_pct(slow_ratio_pct));
`default_nettype wire

/* dv/switch_load_model.sv */
`timescale 1ns/1ps
`default_nettype none
module switch_load_model #(
    parameter int NCH = 4
) (
    // Gate drive and load control
    input  wire logic [NCH-1:0] mosfet_drive,
    input  wire logic [NCH-1:0] overload,
    input  wire logic           severe,
    // Comparator outputs
    output logic      [NCH-1:0] slow_trip,
    output logic      [NCH-1:0] fast_trip
);
    // Current flows only while gated on, so trips vanish once drive drops
    assign slow_trip = mosfet_drive & overload;
    assign fast_trip = mosfet_drive & overload & {NCH{severe}};
endmodule : switch_load_model
`default_nettype wire

/* dv/channel_enable_and_trip_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_enable_and_trip_config_tb;
    import channel_ctrl_pkg::*;
    logic        clock = 0, srst = 1, reg_wr = 0, supply_ok = 1, strap = 1, severe = 0, pg;
    logic [7:0]  reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [3:0]  req = 0, crit = 0, overload = 0, slow, fast, drive;
    logic [31:0] pct;
    group_mode_e gm = GROUP_INDEP;
    prot_mode_e  pm = PROT_ALERT;
    int          n_errors = 0, samples_checked = 0, en_m = 0, seed = 32'h0ae2;
    initial begin
        forever #2.5 clock = ~clock;
    end
    channel_enable_and_trip_config channel_enable_and_trip_config_i (.clock(clock), .srst(srst), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .supply_ok(supply_ok),
        .hardware_enable_strap(strap), .group_mode(gm), .prot_mode(pm), .switch_request_state(req),
        .slow_trip(slow), .fast_trip(fast), .critical_fault(crit), .mosfet_drive(drive),
        .power_good_out(pg), .slow_ratio_pct(pct));
    switch_load_model switch_load_model_i (.mosfet_drive(drive), .overload(overload), .severe(severe),
        .slow_trip(slow), .fast_trip(fast));
    // ----------------------------------------
    // Model and tasks
    // ----------------------------------------
    function automatic logic [3:0] maj_m(input int en, input logic [3:0] r);
        for (int i = 0; i < 4; i++)
            maj_m[i] = ((en >> (2 * i)) % 2 + (en >> (2 * i + 1)) % 2 + r[i]) >= 2;
    endfunction : maj_m
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        if (a == 8'h69) en_m = d;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        @(posedge clock);
        #1 cmp(reg_rdata, e);
    endtask : rd
    // Drive settles within a few edges; off masks channels held down by faults
    task automatic pins(input logic [3:0] off);
        repeat (4) @(posedge clock);
        #1 cmp(drive, supply_ok ? maj_m(en_m, req) & ~off : 4'h0);
    endtask : pins
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        #50us;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        en_m = 8'haa;
        rd(8'h69, 8'haa);
        rd(8'h5e, 8'hff);
        rd(8'h33, 8'h00);
        cmp(pct, {4{8'd200}});
        $display("test reset done");
        for (int k = 0; k < 9; k++) begin
            @(posedge clock);
            gm  <= group_mode_e'(k % 3);
            pm  <= prot_mode_e'(k / 3);
            req <= 4'($random(seed));
            wr(8'h60, 8'hff);
            rd(8'h60, {2'(k / 3), 2'(k % 3), req});
            wr(8'h69, 8'($random(seed)));
            pins(4'h0);
        end
        $display("test status done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h5e, {4{2'(c)}});
            rd(8'h5e, {4{2'(c)}});
            cmp(pct, {4{8'(125 + 25 * c)}});
        end
        $display("test ratio done");
        @(posedge clock);
        supply_ok <= 1'b0;
        strap     <= 1'b0;
        pins(4'h0);
        cmp(pg, 1'b0);
        @(posedge clock);
        supply_ok <= 1'b1;
        en_m = en_m & 8'h55;
        rd(8'h69, 8'(en_m));
        $display("test lockout done");
        for (int k = 0; k < 3; k++) begin
            wr(8'h69, 8'hff);
            @(posedge clock);
            gm       <= group_mode_e'(k);
            overload <= 4'h1;
            severe   <= k[0];
            pins(k == 0 ? 4'hf : k == 1 ? 4'h5 : 4'h1);
            @(posedge clock);
            overload <= 4'h0;
            wr(8'h69, 8'h00);
            wr(8'h69, 8'hff);
            pins(4'h0);
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            pm   <= prot_mode_e'(k);
            crit <= 4'h2;
            pins(k == 2 ? 4'h2 : 4'h0);
            cmp(pg, k == 0);
            @(posedge clock);
            crit <= 4'h0;
            wr(8'h69, 8'h00);
            wr(8'h69, 8'hff);
        end
        $display("test faults done");
        end_of_test();
    end
endmodule : channel_enable_and_trip_config_tb
`default_nettype wire
